// >>> logic/apdp_port.sv
// Parallel host port of a four-channel 14-bit converter: result bus,
// channel select register, busy and per-conversion done strobe.
// Assumes host strobes are asynchronous pins; the converter core hands in
// raw 14-bit codes on conv_code whenever a channel conversion finishes.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Results appear on a 14-bit bus, bit 13 most significant.
// - Two's complement for bipolar variants, straight binary for unipolar.
// - Bits 13 to 4 are output only, three-state, never sampled.
// - Bits 3 to 0 drive only during reads, otherwise act as inputs.
// - Host writes channel select via low bits with chip select and write.
// - Select bit 0 enables channel 1 up to bit 3 for channel 4.
// - Active-low done output idles high, pulses low per channel conversion.
// - Select input high uses register, low uses hardware channel pins.
// - Channel set latched on sample start rising edge.
// - Busy rises at sample start and holds until all selected converted.
module apdp_port
    import apdp_pkg::*;
#(
    parameter bit BIPOLAR = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [3:0] shared_low_bits_in,
    output logic [3:0] shared_low_bits_out,
    output logic [3:0] shared_low_bits_oe,
    output logic [7:0] result_bits_high,
    output logic [1:0] result_bits_mid,
    output logic result_bits_hi_oe,
    input wire logic sample_start_n,
    input wire logic hw_sw_sel,
    input wire logic [3:0] hw_channel_pins,
    input wire logic [13:0] conv_code,
    output logic busy,
    output logic eoc_n,
    output logic fifo_overrun
);
    // Two-stage synchronisers for every pin; strobes and data lines share
    // one depth, so a strobe sample and its data sample line up
    logic [8:0] s1_r;
    logic [8:0] s2_r;
    logic [3:0] d1_r;
    logic [3:0] d2_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_r <= 9'h1ff;
            s2_r <= 9'h1ff;
            d1_r <= 4'h0;
            d2_r <= 4'h0;
        end else begin
            s1_r <= {cs_n, rd_n, wr_n, sample_start_n, hw_sw_sel, hw_channel_pins};
            s2_r <= s1_r;
            d1_r <= shared_low_bits_in;
            d2_r <= d1_r;
        end
    end

    // Synchronised pin views
    wire cs_s_n = s2_r[8];
    wire rd_s_n = s2_r[7];
    wire wr_s_n = s2_r[6];
    wire st_s_n = s2_r[5];
    wire hs_s = s2_r[4];
    wire [3:0] pins_s = s2_r[3:0];

    // Edge history for strobes
    logic st_prev_r;
    logic wr_prev_r;
    logic rd_prev_r;
    wire wr_act = !cs_s_n && !wr_s_n;
    wire rd_act = !cs_s_n && !rd_s_n;
    wire st_rise = st_s_n && !st_prev_r;
    wire wr_end = wr_prev_r && !wr_act;   // Capture at strobe end, data settled
    wire rd_end = rd_prev_r && !rd_act;

    // Write data staged while the strobe is still seen active; the commit at
    // strobe end then does not rely on the host holding data afterwards
    logic [3:0] wdat_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) wdat_r <= CHSEL_RESET;
        else if (wr_act) wdat_r <= d2_r;
    end

    // Channel select register, bit n enables channel n+1
    logic [3:0] chsel_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) chsel_r <= CHSEL_RESET;
        else if (wr_end) chsel_r <= wdat_r;
    end

    // Sequence state
    apdp_state_t state_r;
    apdp_state_t state_nxt;
    logic [3:0] seq_r;
    logic [CH_IDX_W-1:0] ch_r;
    logic [CNT_W-1:0] cnt_r;

    // State decodes shared by the sequencer and its counters
    wire in_idle = (state_r == APDP_IDLE);
    wire in_conv = (state_r == APDP_CONV);
    wire in_done = (state_r == APDP_DONE);
    wire seq_go = in_idle && st_rise; // A start while busy is ignored
    wire [3:0] sel_now = hs_s ? chsel_r : pins_s;
    wire [3:0] remain = seq_r & ~((4'h1 << ch_r) - 4'h1);
    wire ch_on = seq_r[ch_r]; // bit n is channel n+1
    wire conv_fin = in_conv && (cnt_r == CONV_CYC[CNT_W-1:0] - 1'b1);
    wire last_ch = (ch_r == 2'd3) || ((seq_r >> ch_r) == 4'h1);
    wire fifo_in_ready;

    // Next state: skip unselected channels, a full FIFO stalls the sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            APDP_IDLE: if (st_rise && sel_now != 4'h0) state_nxt = APDP_CONV;
            APDP_CONV: if (conv_fin && fifo_in_ready) state_nxt = APDP_DONE;
            APDP_DONE: if (last_ch || remain == 4'h0) state_nxt = APDP_IDLE;
                       else state_nxt = APDP_CONV;
            default: state_nxt = APDP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= APDP_IDLE;
            seq_r <= 4'h0;
            ch_r <= '0;
            cnt_r <= '0;
            st_prev_r <= 1'b1;
            wr_prev_r <= 1'b0;
            rd_prev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            st_prev_r <= st_s_n;
            wr_prev_r <= wr_act;
            rd_prev_r <= rd_act;
            if (seq_go) begin
                seq_r <= sel_now;
                ch_r <= '0;
                cnt_r <= '0;
            end else if (in_conv && !ch_on) begin
                ch_r <= ch_r + 1'b1; // Unselected channel costs one cycle
            end else if (in_conv && !conv_fin) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (in_done) begin
                ch_r <= ch_r + 1'b1;
                cnt_r <= '0;
            end
        end
    end

    // Result coding: flip MSB for two's complement variants
    wire [13:0] coded = BIPOLAR ? (conv_code ^ BIPOLAR_FLIP) : conv_code;
    wire push = conv_fin && ch_on && fifo_in_ready;
    wire [13:0] head;
    wire head_valid;

    // Eight-word buffer decouples the host's read pace from the conversions;
    // when it is full the sequence waits rather than dropping a result
    apdp_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(conv_fin && ch_on),
        .in_ready(fifo_in_ready),
        .in_data(coded),
        .out_valid(head_valid),
        .out_ready(rd_end),
        .out_data(head)
    );

    // Done pulse width counter; the pulse restarts on every accepted result
    logic [CNT_W-1:0] eoc_cnt_r;
    wire eoc_hold = (eoc_cnt_r > 12'h001);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            eoc_cnt_r <= '0;
            eoc_n <= 1'b1;
        end else begin
            if (push) eoc_cnt_r <= EOC_CYC[CNT_W-1:0];
            else if (eoc_cnt_r != '0) eoc_cnt_r <= eoc_cnt_r - 1'b1;
            eoc_n <= !(push || eoc_hold);
        end
    end

    // Busy follows the next state so it rises with the accepted start.
    // Overrun stays high for as long as a finished result waits for room.
    wire stall = conv_fin && ch_on && !fifo_in_ready;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            fifo_overrun <= 1'b0;
        end else begin
            busy <= (state_nxt != APDP_IDLE);
            fifo_overrun <= stall;
        end
    end

    // Drive values taken from the FIFO head; an empty FIFO reads as zero
    wire [7:0] hi_drv = head_valid ? head[13:6] : 8'h00;
    wire [1:0] mid_drv = head_valid ? head[5:4] : 2'h0;
    wire [3:0] low_drv = head_valid ? head[3:0] : 4'h0;

    // Bus drive registered; floats outside a read (late by sync delay)
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            result_bits_high <= 8'h00;
            result_bits_mid <= 2'h0;
            shared_low_bits_out <= 4'h0;
            result_bits_hi_oe <= 1'b0;
            shared_low_bits_oe <= 4'h0;
        end else begin
            result_bits_high <= hi_drv;
            result_bits_mid <= mid_drv;
            shared_low_bits_out <= low_drv;
            result_bits_hi_oe <= rd_act;
            shared_low_bits_oe <= {4{rd_act}};
        end
    end
endmodule // apdp_port
`default_nettype wire

// >>> logic/apdp_pkg.sv
// Package for the parallel result port: widths, codes, timing counts.
// Assumes a 250 MHz system clock; shared by the port logic and the bench.
package apdp_pkg;
    localparam int RES_W = 14;              // Result bus width, bit 13 is MSB
    localparam int LOW_W = 4;               // Shared low lines width
    localparam int CH_N = 4;                // Channel count
    localparam int CH_IDX_W = 2;
    localparam logic [3:0] CHSEL_RESET = 4'h0;  // Select register after reset
    localparam int CONV_NS = 2400;          // Conversion time per channel
    localparam int CLK_MHZ = 250;
    localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int EOC_NS = 20;             // Done pulse width
    localparam int EOC_CYC = (EOC_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 12;
    localparam int FIFO_DEPTH = 8;
    localparam logic [13:0] BIPOLAR_FLIP = 14'h2000; // MSB flip for two's complement
    typedef enum logic [1:0] {
        APDP_IDLE = 2'b00,
        APDP_CONV = 2'b01,
        APDP_DONE = 2'b10
    } apdp_state_t;
endpackage

// >>> logic/apdp_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock domain shared by writer and reader.
`timescale 1ns/100ps
`default_nettype none
module apdp_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    // Honest flags straight from the occupancy count
    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop) rp_r <= rp_r + 1'b1;
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
    // Storage has no reset; empty flag guards reads
    always_ff @(posedge clk_sys) begin
        if (push) mem_r[wp_r] <= in_data;
    end
endmodule // apdp_fifo
`default_nettype wire

// >>> test/apdp_port_asserts.sv
// Port checks for the parallel result port.
// Assumes host strobes stay put for several cycles, as the bench holds them.
`timescale 1ns/100ps
`default_nettype none
module apdp_port_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [3:0] shared_low_bits_oe,
    input wire logic result_bits_hi_oe,
    input wire logic sample_start_n,
    input wire logic hw_sw_sel,
    input wire logic [3:0] hw_channel_pins,
    input wire logic busy,
    input wire logic eoc_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Strobes pass two sync flops, so five cycles cover the lag
    a_float_when_idle: assert property ((cs_n || rd_n)[*5] |-> !result_bits_hi_oe) else $error("bus driven without read");
    a_drive_on_read: assert property ((!cs_n && !rd_n)[*5] |-> result_bits_hi_oe) else $error("read not driven");
    a_low_follows_high: assert property (shared_low_bits_oe == {4{result_bits_hi_oe}}) else $error("low oe split");
    a_write_no_drive: assert property ((!wr_n && rd_n)[*5] |-> shared_low_bits_oe == 4'h0) else $error("drive in write");
    a_done_width: assert property ($fell(eoc_n) |-> !eoc_n[*5] ##1 eoc_n) else $error("done pulse width");
    a_done_in_seq: assert property ($fell(eoc_n) |-> $past(busy)) else $error("done outside sequence");
    a_busy_on_start: assert property ($rose(sample_start_n) && !busy && !hw_sw_sel && hw_channel_pins != 4'h0
        |-> ##[1:6] busy) else $error("busy late");
    a_busy_cause: assert property ($rose(busy) |-> sample_start_n) else $error("busy without start");
    a_busy_min: assert property ($rose(busy) |-> busy[*8]) else $error("busy too short");
    c_done: cover property ($fell(eoc_n));
    c_seq_end: cover property ($fell(busy));
    c_write: cover property (!cs_n && !wr_n);
endmodule // apdp_port_asserts
bind apdp_port apdp_port_asserts i_apdp_port_asserts (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .shared_low_bits_oe(shared_low_bits_oe), .result_bits_hi_oe(result_bits_hi_oe),
    .sample_start_n(sample_start_n), .hw_sw_sel(hw_sw_sel), .hw_channel_pins(hw_channel_pins),
    .busy(busy), .eoc_n(eoc_n));
`default_nettype wire

// >>> test/apdp_host_bus.sv
// Host side of the shared low data lines: resolves the wire level.
// Assumes the bench sets host_oe only while it writes.
`timescale 1ns/100ps
`default_nettype none
module apdp_host_bus (
    input wire logic [3:0] dev_out,
    input wire logic [3:0] dev_oe,
    input wire logic [3:0] host_out,
    input wire logic host_oe,
    output logic [3:0] lvl
);
    logic [3:0] last = 4'h0;
    // Undriven lines show the inverse so stale data never passes
    always @* begin
        if (host_oe) begin
            lvl = host_out;
            last = host_out;
        end else if (dev_oe != 4'h0) begin
            lvl = dev_out;
            last = dev_out;
        end else begin
            lvl = ~last;
        end
    end
endmodule // apdp_host_bus
`default_nettype wire

// >>> test/apdp_port_tb.sv
// Self-checking bench for the parallel result port.
// Assumes bipolar coding and the host bus model beside the port.
`timescale 1ns/100ps
`default_nettype none
module apdp_port_tb;
    import apdp_pkg::*;
    logic clk_sys, rst, cs_n, rd_n, wr_n, host_oe, hi_oe, start_n, sel, busy, eoc_n, ovr;
    logic [3:0] lvl, low_out, low_oe, host_out, pins;
    logic [7:0] hi_b;
    logic [1:0] mid;
    logic [13:0] code;
    int fail_count = 0;
    int check_count = 0;
    apdp_port #(.BIPOLAR(1'b1)) i_apdp_port (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .shared_low_bits_in(lvl), .shared_low_bits_out(low_out), .shared_low_bits_oe(low_oe),
        .result_bits_high(hi_b), .result_bits_mid(mid), .result_bits_hi_oe(hi_oe), .sample_start_n(start_n),
        .hw_sw_sel(sel), .hw_channel_pins(pins), .conv_code(code), .busy(busy), .eoc_n(eoc_n), .fifo_overrun(ovr));
    apdp_host_bus i_apdp_host_bus (.dev_out(low_out), .dev_oe(low_oe), .host_out(host_out), .host_oe(host_oe),
        .lvl(lvl));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish;
        if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Data held one cycle past the strobes, like a real host
    task automatic host_write(input logic [3:0] v);
        host_out = v; host_oe = 1'b1; cs_n = 1'b0; wr_n = 1'b0; cyc(5);
        cs_n = 1'b1; wr_n = 1'b1; cyc(1); host_oe = 1'b0; cyc(5);
    endtask
    // One full read; the whole 14-bit word is compared
    task automatic read_word(input logic [13:0] exp);
        cs_n = 1'b0; rd_n = 1'b0; cyc(6);
        chk({hi_b, mid, lvl}, exp);
        cs_n = 1'b1; rd_n = 1'b1; cyc(6);
    endtask
    // Counts done pulses until busy drops; optional write mid-sequence
    task automatic run_seq(input logic [13:0] n_exp, input logic [3:0] late);
        logic seen, p;
        int n;
        seen = 1'b0; p = 1'b1; n = 0;
        start_n = 1'b0; cyc(4); start_n = 1'b1; cyc(8);
        if (late != 4'h0) host_write(late);
        for (int i = 0; i < 4000 && !(seen && !busy); i++) begin
            cyc(1);
            if (p && !eoc_n) n++;
            p = eoc_n; seen = seen | busy;
        end
        if (!(seen && !busy)) begin
            fail_count++;
            $display("MISMATCH %0t sequence did not end", $time);
            tally_and_finish();
        end
        chk(14'(n), n_exp);
    endtask
    task automatic s_hw_pins;
        sel = 1'b0; pins = 4'b0101; code = 14'h1234;
        run_seq(14'h0002, 4'h0);
        repeat (2) read_word(14'h3234);
    endtask
    task automatic s_sw_latch;
        host_write(4'b1000); sel = 1'b1; pins = 4'hF; code = 14'h0ABC;
        run_seq(14'h0001, 4'hF);
        read_word(14'h2ABC);
        code = 14'h3FFF;
        run_seq(14'h0004, 4'h0);
        repeat (4) read_word(14'h1FFF);
    endtask
    task automatic s_empty_read;
        read_word(14'h0000);
    endtask
    // Twelve results against eight words: the ninth waits until a read frees room
    task automatic s_overrun;
        code = 14'h0155;
        repeat (2) run_seq(14'h0004, 4'h0);
        start_n = 1'b0;
        cyc(4);
        start_n = 1'b1;
        cyc(700);
        chk({13'h0000, ovr}, 14'h0001);
        chk({13'h0000, eoc_n}, 14'h0001);
        chk({13'h0000, busy}, 14'h0001);
        repeat (8) read_word(14'h2155);
        for (int i = 0; i < 3000 && busy; i++) cyc(1);
        chk({13'h0000, busy}, 14'h0000);
        if (busy) tally_and_finish();
        repeat (4) read_word(14'h2155);
    endtask
    // Mid-run reset clears the select register, so a register-mode start is refused
    task automatic s_reset;
        rst = 1'b1;
        cyc(4);
        rst = 1'b0;
        cyc(4);
        start_n = 1'b0;
        cyc(4);
        start_n = 1'b1;
        cyc(10);
        chk({13'h0000, busy}, 14'h0000);
        chk({13'h0000, eoc_n}, 14'h0001);
        read_word(14'h0000);
    endtask
    initial begin
        rst = 1'b1; cs_n = 1'b1; rd_n = 1'b1; wr_n = 1'b1; host_oe = 1'b0; host_out = 4'h0;
        start_n = 1'b1; sel = 1'b0; pins = 4'h0; code = 14'h0000;
        cyc(4); rst = 1'b0; cyc(4);
        s_hw_pins();
        s_sw_latch();
        s_empty_read();
        s_overrun();
        s_reset();
        tally_and_finish();
    end
endmodule // apdp_port_tb
`default_nettype wire
